/* verilog/tps_pkg.sv */
package tps_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	// soft reset pulse length seen by the datapath
	localparam int SOFT_RESET_NS = 320;
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = $clog2(SOFT_RESET_CYCLES + 1);

	// ----------------------------------------
	// management devices and register offsets
	// ----------------------------------------
	localparam logic [4:0] DEV_PMA = 5'h01;
	localparam logic [4:0] DEV_PCS = 5'h03;
	localparam logic [15:0] OFS_PCS_CONTROL_ONE = 16'h0000;
	localparam logic [15:0] OFS_PCS_STATUS_ONE = 16'h0001;
	localparam logic [15:0] OFS_TX_TEST_PATTERN_CONTROL = 16'h08f8;
	localparam logic [15:0] OFS_PMA_LINK_HEALTH = 16'h8302;
	localparam logic [15:0] OFS_NOISE_METRIC = 16'h830b;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] RST_PCS_CONTROL_ONE = 16'h0000;
	localparam logic [15:0] RST_PCS_STATUS_ONE = 16'h0002;
	localparam logic [15:0] RST_TX_TEST_PATTERN_CONTROL = 16'h0000;
	localparam logic [15:0] RST_PMA_LINK_HEALTH = 16'h0000;
	localparam logic [15:0] RST_NOISE_METRIC = 16'h0000;
	localparam logic [15:0] RST_MMD_ADDRESS = 16'h0000;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTL1_SOFT_RESET_BIT = 15;
	localparam int CTL1_LOOPBACK_BIT = 14;
	localparam int CTL1_POWER_DOWN_BIT = 11;
	localparam int TEST_SEL_HI = 15;
	localparam int TEST_SEL_LO = 13;
	localparam int LH_FAR_HELD_BIT = 9;
	localparam int LH_FAR_BIT = 8;
	localparam int LH_NEAR_HELD_BIT = 7;
	localparam int LH_NEAR_BIT = 6;
	localparam int LH_UNSCR_HELD_BIT = 5;
	localparam int LH_UNSCR_BIT = 4;
	localparam int LH_LINK_HELD_BIT = 1;
	localparam int LH_LINK_BIT = 0;
	localparam int LATCH_COUNT = 4;

	// ----------------------------------------
	// transmit test patterns and symbols
	// ----------------------------------------
	localparam logic [2:0] PAT_NORMAL = 3'h0;
	localparam logic [2:0] PAT_ALTERNATE = 3'h1;
	localparam logic [2:0] PAT_DROOP = 3'h2;
	localparam logic [2:0] PAT_IDLE_MASTER = 3'h3;
	localparam int DROOP_RUN = 10;
	localparam logic [1:0] SYM_ZERO = 2'h0;
	localparam logic [1:0] SYM_PLUS = 2'h1;
	localparam logic [1:0] SYM_MINUS = 2'h3;

	// ----------------------------------------
	// management frame
	// ----------------------------------------
	localparam int PREAMBLE_ONES = 32;
	localparam int HDR_BITS = 14;
	localparam int DATA_BITS = 16;
	localparam logic [1:0] FRAME_START = 2'h0;
	localparam logic [1:0] OP_ADDRESS = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ_INC = 2'h2;

	typedef enum logic [1:0] {
		MD_PREAMBLE,
		MD_HEADER,
		MD_TURN,
		MD_DATA
	} tps_mdio_e;

endpackage

/* verilog/tps_tx_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tps_tx_if;
	logic [2:0] pattern_select;
	logic symbol_tick;
	logic [1:0] data_symbol;
	logic [1:0] tx_symbol;
	logic force_master;
	logic force_idle;

	modport gen (
		input pattern_select, symbol_tick, data_symbol,
		output tx_symbol, force_master, force_idle
	);
	modport ctl (
		output pattern_select, symbol_tick, data_symbol,
		input tx_symbol, force_master, force_idle
	);
endinterface
`default_nettype wire

/* verilog/tps_latch_low.sv */
`timescale 1ns/1ps
`default_nettype none
module tps_latch_low (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// condition and read side effect
	input wire logic live,
	input wire logic clear,
	output logic held
);
	typedef struct packed {
		logic held;
	} tps_latch_s;

	tps_latch_s r;
	tps_latch_s next_r;

	// a drop in the clearing cycle still lands, since live is already low then
	always_comb begin
		next_r = r;
		if (clear) begin
			next_r.held = live; // RULE17
		end else begin
			next_r.held = r.held & live; // RULE16
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign held = r.held;
endmodule
`default_nettype wire

/* verilog/tps_tx_pattern.sv */
`timescale 1ns/1ps
`default_nettype none
module tps_tx_pattern
	import tps_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// pattern control and symbol stream
	tps_tx_if.gen tx
);
	typedef struct packed {
		logic [2:0] mode;
		logic [3:0] run;
		logic minus;
		logic [1:0] symbol;
	} tps_pattern_s;

	tps_pattern_s r;
	tps_pattern_s next_r;

	always_comb begin
		next_r = r;
		next_r.mode = tx.pattern_select;
		// restart each pattern cleanly when the selection changes
		if (tx.pattern_select != r.mode) begin
			next_r.run = '0;
			next_r.minus = 1'b0;
		end else if (tx.symbol_tick) begin
			case (r.mode)
				PAT_ALTERNATE: begin
					next_r.symbol = r.minus ? SYM_MINUS : SYM_PLUS; // RULE2
					next_r.minus = ~r.minus; // RULE2
				end
				PAT_DROOP: begin
					next_r.symbol = r.minus ? SYM_MINUS : SYM_PLUS; // RULE3
					if (r.run == 4'(DROOP_RUN - 1)) begin
						next_r.run = '0;
						next_r.minus = ~r.minus; // RULE3
					end else begin
						next_r.run = r.run + 4'h1;
					end
				end
				default: begin
					// normal, idle-as-master and reserved codes pass datapath symbols
					next_r.symbol = tx.data_symbol; // RULE1 RULE4
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '{mode: PAT_NORMAL, run: 4'h0, minus: 1'b0, symbol: SYM_ZERO};
		end else begin
			r <= next_r;
		end
	end

	assign tx.tx_symbol = r.symbol;
	assign tx.force_master = (r.mode == PAT_IDLE_MASTER); // RULE4
	assign tx.force_idle = (r.mode == PAT_IDLE_MASTER); // RULE4
endmodule
`default_nettype wire

/* verilog/tps_top.sv */
// Overview of operation
// RULE1: test pattern control resets to normal transmission
// RULE2: code 001 sends alternating plus, minus symbols
// RULE3: code 010 sends ten plus, ten minus
// RULE4: code 011 transmits idle as master
// RULE5: link health read clears latched-low bits
// RULE6: bit 8 far receiver, bit 9 held
// RULE7: bit 6 near receiver, bit 7 held
// RULE8: bit 4 unscramble lock, bit 5 held
// RULE9: bit 0 link up, bit 1 held
// RULE10: noise metric is read-only sixteen-bit value
// RULE11: host uses 0.64422 idle power reference
// RULE12: soft reset self-clears, shared with attachment
// RULE13: loopback bit returns transmit data to receive
// RULE14: power-down bit mirrors attachment power-down
// RULE15: status one reads 0x0002 only
// RULE16: held bit low after any drop
// RULE17: after clearing read, held follows live again
`timescale 1ns/1ps
`default_nettype none
module tps_top
	import tps_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h00
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	// live link conditions
	input wire logic far_receiver_ok,
	input wire logic near_receiver_ok,
	input wire logic unscramble_lock_ok,
	input wire logic link_up_live,
	input wire logic [15:0] noise_metric_value,
	// attachment side control
	input wire logic attachment_soft_reset,
	input wire logic attachment_power_down_wr,
	input wire logic attachment_power_down,
	// datapath control
	output logic coding_sublayer_soft_reset,
	output logic coding_sublayer_loopback,
	output logic coding_sublayer_power_down,
	output logic [2:0] tx_pattern_select,
	// transmit symbols
	input wire logic symbol_tick,
	input wire logic [1:0] data_symbol,
	output logic [1:0] tx_symbol,
	output logic force_master,
	output logic force_idle
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] mdc_sync;
		logic [2:0] mdio_sync;
		logic mdc_lvl;
		logic mdio_lvl;
		tps_mdio_e state;
		logic [5:0] cnt;
		logic [13:0] hdr;
		logic [15:0] shift;
		logic ours;
		logic rd;
		logic pcs_dev;
		logic [1:0] op;
		logic [15:0] addr_pma;
		logic [15:0] addr_pcs;
		logic out;
		logic oe;
		logic [2:0] pattern;
		logic loopback;
		logic power_down;
		logic [RST_CNT_W-1:0] rst_cnt;
	} tps_top_s;

	tps_top_s r;
	tps_top_s next_r;

	logic mdc_rise;
	logic bit_in;
	logic link_read;
	logic soft_active;
	logic [15:0] word_in;
	logic [LATCH_COUNT-1:0] live_vec;
	logic [LATCH_COUNT-1:0] held_vec;
	logic [15:0] pcs_control_one;
	logic [15:0] pma_link_health;
	logic [15:0] tx_test_pattern_control;

	// ----------------------------------------
	// latched-low copies
	// ----------------------------------------
	assign live_vec = {far_receiver_ok, near_receiver_ok, unscramble_lock_ok, link_up_live};

	generate
		for (genvar i = 0; i < LATCH_COUNT; i++) begin : g_held
			tps_latch_low u_held (
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.live(live_vec[i]),
				.clear(link_read | soft_active), // RULE5
				.held(held_vec[i])
			);
		end
	endgenerate

	// ----------------------------------------
	// register images
	// ----------------------------------------
	assign soft_active = (r.rst_cnt != '0);

	always_comb begin
		pcs_control_one = RST_PCS_CONTROL_ONE;
		pcs_control_one[CTL1_SOFT_RESET_BIT] = soft_active; // RULE12
		pcs_control_one[CTL1_LOOPBACK_BIT] = r.loopback;
		pcs_control_one[CTL1_POWER_DOWN_BIT] = r.power_down; // RULE14
		tx_test_pattern_control = RST_TX_TEST_PATTERN_CONTROL;
		tx_test_pattern_control[TEST_SEL_HI:TEST_SEL_LO] = r.pattern;
		pma_link_health = RST_PMA_LINK_HEALTH;
		pma_link_health[LH_FAR_HELD_BIT] = held_vec[3]; // RULE6
		pma_link_health[LH_FAR_BIT] = far_receiver_ok; // RULE6
		pma_link_health[LH_NEAR_HELD_BIT] = held_vec[2]; // RULE7
		pma_link_health[LH_NEAR_BIT] = near_receiver_ok; // RULE7
		pma_link_health[LH_UNSCR_HELD_BIT] = held_vec[1]; // RULE8
		pma_link_health[LH_UNSCR_BIT] = unscramble_lock_ok; // RULE8
		pma_link_health[LH_LINK_HELD_BIT] = held_vec[0]; // RULE9
		pma_link_health[LH_LINK_BIT] = link_up_live; // RULE9
	end

	function automatic logic [15:0] read_word(
		input logic pcs_dev,
		input logic [15:0] a,
		input logic [15:0] ctl1,
		input logic [15:0] test_ctl,
		input logic [15:0] health,
		input logic [15:0] noise
	);
		logic [15:0] w;
		w = 16'h0000;
		if (pcs_dev && a == OFS_PCS_CONTROL_ONE) begin
			w = ctl1;
		end else if (pcs_dev && a == OFS_PCS_STATUS_ONE) begin
			w = RST_PCS_STATUS_ONE; // RULE15
		end else if (!pcs_dev && a == OFS_TX_TEST_PATTERN_CONTROL) begin
			w = test_ctl;
		end else if (!pcs_dev && a == OFS_PMA_LINK_HEALTH) begin
			w = health;
		end else if (!pcs_dev && a == OFS_NOISE_METRIC) begin
			w = noise; // RULE10
		end
		return w;
	endfunction

	// ----------------------------------------
	// management frame engine
	// ----------------------------------------
	always_comb begin
		logic [13:0] h;
		logic [15:0] a;
		logic hit;
		logic start_reset;
		h = '0;
		a = '0;
		hit = 1'b0;
		start_reset = attachment_soft_reset; // RULE12
		next_r = r;
		link_read = 1'b0;
		// first stage feeds only the second; a change counts once stages two and three agree
		next_r.mdc_sync = {r.mdc_sync[1:0], mdc};
		next_r.mdio_sync = {r.mdio_sync[1:0], mdio_in};
		if (r.mdc_sync[1] == r.mdc_sync[2]) begin
			next_r.mdc_lvl = r.mdc_sync[2];
		end
		if (r.mdio_sync[1] == r.mdio_sync[2]) begin
			next_r.mdio_lvl = r.mdio_sync[2];
		end
		mdc_rise = next_r.mdc_lvl & ~r.mdc_lvl;
		bit_in = next_r.mdio_lvl;
		word_in = {r.shift[14:0], bit_in};
		if (mdc_rise) begin
			case (r.state)
				MD_PREAMBLE: begin
					if (bit_in) begin
						if (r.cnt != 6'(PREAMBLE_ONES)) begin
							next_r.cnt = r.cnt + 6'h01;
						end
					end else if (r.cnt == 6'(PREAMBLE_ONES)) begin
						next_r.state = MD_HEADER;
						next_r.hdr = '0;
						next_r.cnt = 6'h01;
					end else begin
						next_r.cnt = '0;
					end
				end
				MD_HEADER: begin
					h = {r.hdr[12:0], bit_in};
					next_r.hdr = h;
					next_r.cnt = r.cnt + 6'h01;
					if (r.cnt == 6'(HDR_BITS - 1)) begin
						next_r.state = MD_TURN;
						next_r.cnt = '0;
						next_r.op = h[11:10];
						next_r.rd = h[11];
						next_r.pcs_dev = (h[4:0] == DEV_PCS);
						hit = (h[13:12] == FRAME_START) && (h[9:5] == PHY_ADDR)
							&& (h[4:0] == DEV_PMA || h[4:0] == DEV_PCS);
						next_r.ours = hit;
						a = (h[4:0] == DEV_PCS) ? r.addr_pcs : r.addr_pma;
						if (hit && h[11]) begin
							next_r.shift = read_word(h[4:0] == DEV_PCS, a, pcs_control_one,
								tx_test_pattern_control, pma_link_health, noise_metric_value);
							link_read = (h[4:0] == DEV_PMA) && (a == OFS_PMA_LINK_HEALTH); // RULE5
							if (h[11:10] == OP_READ_INC) begin
								if (h[4:0] == DEV_PCS) begin
									next_r.addr_pcs = r.addr_pcs + 16'h0001;
								end else begin
									next_r.addr_pma = r.addr_pma + 16'h0001;
								end
							end
						end
					end
				end
				MD_TURN: begin
					if (r.cnt == '0) begin
						next_r.cnt = 6'h01;
						if (r.ours && r.rd) begin
							next_r.oe = 1'b1;
							next_r.out = 1'b0;
						end
					end else begin
						next_r.state = MD_DATA;
						next_r.cnt = '0;
						if (r.ours && r.rd) begin
							next_r.out = r.shift[15];
							next_r.shift = {r.shift[14:0], 1'b0};
						end
					end
				end
				MD_DATA: begin
					next_r.cnt = r.cnt + 6'h01;
					if (r.rd) begin
						next_r.out = r.shift[15];
						next_r.shift = {r.shift[14:0], 1'b0};
					end else begin
						next_r.shift = word_in;
					end
					if (r.cnt == 6'(DATA_BITS - 1)) begin
						next_r.state = MD_PREAMBLE;
						next_r.cnt = '0;
						next_r.oe = 1'b0;
						next_r.out = 1'b0;
						if (r.ours && r.op == OP_ADDRESS) begin
							if (r.pcs_dev) begin
								next_r.addr_pcs = word_in;
							end else begin
								next_r.addr_pma = word_in;
							end
						end else if (r.ours && r.op == OP_WRITE) begin
							a = r.pcs_dev ? r.addr_pcs : r.addr_pma;
							// read-only and unmapped words swallow writes
							if (r.pcs_dev && a == OFS_PCS_CONTROL_ONE) begin
								next_r.loopback = word_in[CTL1_LOOPBACK_BIT]; // RULE13
								next_r.power_down = word_in[CTL1_POWER_DOWN_BIT]; // RULE14
								start_reset = start_reset | word_in[CTL1_SOFT_RESET_BIT]; // RULE12
							end else if (!r.pcs_dev && a == OFS_TX_TEST_PATTERN_CONTROL) begin
								next_r.pattern = word_in[TEST_SEL_HI:TEST_SEL_LO];
							end
						end
					end
				end
				default: begin
					next_r.state = MD_PREAMBLE;
				end
			endcase
		end
		if (attachment_power_down_wr) begin
			next_r.power_down = attachment_power_down; // RULE14
		end
		// soft reset holds the control fields at their defaults, then releases on its own
		if (start_reset) begin
			next_r.rst_cnt = RST_CNT_W'(SOFT_RESET_CYCLES); // RULE12
		end else if (soft_active) begin
			next_r.rst_cnt = r.rst_cnt - {{(RST_CNT_W-1){1'b0}}, 1'b1}; // RULE12
		end
		if (start_reset || soft_active) begin
			next_r.pattern = RST_TX_TEST_PATTERN_CONTROL[TEST_SEL_HI:TEST_SEL_LO]; // RULE1
			next_r.loopback = RST_PCS_CONTROL_ONE[CTL1_LOOPBACK_BIT];
			next_r.power_down = RST_PCS_CONTROL_ONE[CTL1_POWER_DOWN_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '{mdc_sync: 3'h0, mdio_sync: 3'h0, mdc_lvl: 1'b0, mdio_lvl: 1'b0,
				state: MD_PREAMBLE, cnt: 6'h00, hdr: 14'h0000, shift: 16'h0000,
				ours: 1'b0, rd: 1'b0, pcs_dev: 1'b0, op: 2'h0,
				addr_pma: RST_MMD_ADDRESS, addr_pcs: RST_MMD_ADDRESS, out: 1'b0, oe: 1'b0,
				pattern: RST_TX_TEST_PATTERN_CONTROL[TEST_SEL_HI:TEST_SEL_LO], // RULE1
				loopback: 1'b0, power_down: 1'b0, rst_cnt: '0};
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// transmit test pattern path
	// ----------------------------------------
	tps_tx_if tx_link ();

	assign tx_link.pattern_select = r.pattern;
	assign tx_link.symbol_tick = symbol_tick;
	assign tx_link.data_symbol = data_symbol;

	tps_tx_pattern u_pattern (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tx(tx_link.gen)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign mdio_out = r.out;
	assign mdio_oe = r.oe;
	assign coding_sublayer_soft_reset = soft_active;
	assign coding_sublayer_loopback = r.loopback; // RULE13
	assign coding_sublayer_power_down = r.power_down;
	assign tx_pattern_select = r.pattern;
	assign tx_symbol = tx_link.tx_symbol;
	assign force_master = tx_link.force_master;
	assign force_idle = tx_link.force_idle;
endmodule
`default_nettype wire

/* test/tps_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tps_top_monitor
	import tps_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// attachment side control
	input wire logic attachment_soft_reset,
	input wire logic attachment_power_down_wr,
	input wire logic attachment_power_down,
	// datapath control
	input wire logic coding_sublayer_soft_reset,
	input wire logic coding_sublayer_loopback,
	input wire logic coding_sublayer_power_down,
	input wire logic [2:0] tx_pattern_select,
	// transmit symbols
	input wire logic symbol_tick,
	input wire logic [1:0] data_symbol,
	input wire logic [1:0] tx_symbol,
	input wire logic force_master,
	input wire logic force_idle
);
	// ----------------------------------------
	// ticks counted since the pattern last changed
	// ----------------------------------------
	logic [2:0] sel_q;
	int n;
	wire logic sr = coding_sublayer_soft_reset;
	wire logic same = tx_pattern_select == sel_q;
	always_ff @(posedge sys_clk) begin
		sel_q <= sys_rst ? 3'h0 : tx_pattern_select;
		n <= (sys_rst || !same) ? 0 : n + int'(symbol_tick);
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_sr_run;
		sr[*8] ##1 sr[*8] ##1 !sr;
	endsequence
	// tx_symbol is registered, so each tick is judged exactly one edge on;
	// this keeps back-to-back ticks legal
	sequence s_tick(logic [2:0] p);
		symbol_tick && same && tx_pattern_select == p;
	endsequence
	a_sr_length: assert property ($rose(sr) |-> s_sr_run)
		else $error("soft reset span wrong");
	a_sr_start: assert property (attachment_soft_reset |-> ##[1:3] sr)
		else $error("attachment reset not shared");
	a_sr_clears: assert property (sr && $past(sr) |-> tx_pattern_select == 3'h0 &&
		!coding_sublayer_loopback && !coding_sublayer_power_down)
		else $error("soft reset left controls set");
	a_pd_mirror: assert property (attachment_power_down_wr && !sr && !attachment_soft_reset
		|=> coding_sublayer_power_down == $past(attachment_power_down))
		else $error("power down not mirrored");
	a_alt_order: assert property (s_tick(PAT_ALTERNATE)
		|-> ##1 tx_symbol == ($past(n) % 2 == 1 ? SYM_MINUS : SYM_PLUS))
		else $error("alternate pattern wrong");
	a_droop_order: assert property (s_tick(PAT_DROOP)
		|-> ##1 tx_symbol == ($past(n) % 20 < 10 ? SYM_PLUS : SYM_MINUS))
		else $error("droop pattern wrong");
	a_data_pass: assert property (symbol_tick && same && tx_pattern_select != PAT_ALTERNATE
		&& tx_pattern_select != PAT_DROOP |-> ##1 tx_symbol == $past(data_symbol))
		else $error("data symbol not passed");
	a_idle_master: assert property (same && $past(same) |-> {force_master, force_idle} ==
		{2{tx_pattern_select == PAT_IDLE_MASTER}})
		else $error("master idle flags wrong");
endmodule
bind tps_top tps_top_monitor mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.attachment_soft_reset(attachment_soft_reset),
	.attachment_power_down_wr(attachment_power_down_wr),
	.attachment_power_down(attachment_power_down),
	.coding_sublayer_soft_reset(coding_sublayer_soft_reset),
	.coding_sublayer_loopback(coding_sublayer_loopback),
	.coding_sublayer_power_down(coding_sublayer_power_down),
	.tx_pattern_select(tx_pattern_select), .symbol_tick(symbol_tick),
	.data_symbol(data_symbol), .tx_symbol(tx_symbol),
	.force_master(force_master), .force_idle(force_idle));
`default_nettype wire

/* test/tps_mdio_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tps_mdio_host
	import tps_pkg::*;
#(
	parameter logic [4:0] PORT_ADDR = 5'h00
) (
	// clock
	input wire logic sys_clk,
	// management pins
	output logic mdc,
	output logic mdio_line,
	input wire logic mdio_oe,
	input wire logic mdio_out
);
	// reference power when turning the noise metric into a ratio
	localparam real IDLE_POWER = 0.64422;
	logic drv_en = 1'b0;
	logic drv_bit = 1'b1;
	initial mdc = 1'b0;
	// a released line floats up through the pull-up
	assign mdio_line = mdio_oe ? mdio_out : (drv_en ? drv_bit : 1'b1);
	// eight cycles low, eight high, though the pin filter passes a level held for two samples
	task bitx(input logic en, input logic b, output logic s);
		@(posedge sys_clk);
		mdc <= 1'b0;
		drv_en <= en;
		drv_bit <= b;
		repeat (8) @(posedge sys_clk);
		mdc <= 1'b1;
		s = mdio_line;
		repeat (7) @(posedge sys_clk);
	endtask
	task frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [13:0] hdr;
		logic s;
		int i;
		hdr = {FRAME_START, op, PORT_ADDR, dev};
		rd = wd;
		for (i = 0; i < PREAMBLE_ONES; i++) bitx(1'b1, 1'b1, s);
		for (i = HDR_BITS - 1; i >= 0; i--) bitx(1'b1, hdr[i], s);
		// reads let go of the line from the turnaround on
		bitx(!op[1], 1'b1, s);
		bitx(!op[1], 1'b0, s);
		for (i = DATA_BITS - 1; i >= 0; i--) begin
			bitx(!op[1], wd[i], s);
			if (op[1]) rd[i] = s;
		end
	endtask
endmodule
`default_nettype wire

/* test/tps_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import tps_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mdc, mdio_in, mdio_out, mdio_oe, sr, lb, pd, fm, fi;
	logic a_rst = 1'b0, a_pdw = 1'b0, a_pd = 1'b0, tick = 1'b0;
	logic [3:0] live = 4'hf;
	logic [3:0] held = 4'h0;
	logic [15:0] noise = 16'h0;
	logic [1:0] dsym = 2'h0;
	logic [1:0] txs;
	logic [2:0] psel;
	int bad_count = 0, checks_done = 0;
	always #10 sys_clk = ~sys_clk;
	tps_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .far_receiver_ok(live[3]),
		.near_receiver_ok(live[2]), .unscramble_lock_ok(live[1]), .link_up_live(live[0]),
		.noise_metric_value(noise), .attachment_soft_reset(a_rst),
		.attachment_power_down_wr(a_pdw), .attachment_power_down(a_pd),
		.coding_sublayer_soft_reset(sr), .coding_sublayer_loopback(lb),
		.coding_sublayer_power_down(pd), .tx_pattern_select(psel), .symbol_tick(tick),
		.data_symbol(dsym), .tx_symbol(txs), .force_master(fm), .force_idle(fi));
	tps_mdio_host host (.sys_clk(sys_clk), .mdc(mdc), .mdio_line(mdio_in),
		.mdio_oe(mdio_oe), .mdio_out(mdio_out));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [4:0] dev, input logic [15:0] ofs, input logic [15:0] v);
		logic [15:0] d;
		host.frame(OP_ADDRESS, dev, ofs, d);
		host.frame(OP_WRITE, dev, v, d);
	endtask
	task rd(input logic [4:0] dev, input logic [15:0] ofs, output logic [15:0] v);
		logic [15:0] d;
		host.frame(OP_ADDRESS, dev, ofs, d);
		host.frame(2'h3, dev, 16'h0, v);
	endtask
	// model: a read shows held and live, then held takes the live value again
	task health;
		logic [15:0] v;
		host.frame(2'h3, DEV_PMA, 16'h0, v);
		chk("health", v, {6'h0, held[3], live[3], held[2], live[2], held[1], live[1], 2'h0,
			held[0], live[0]});
		held = live;
	endtask
	task count_sr(input int cyc, output int n);
		n = 0;
		repeat (cyc) begin
			@(posedge sys_clk);
			#1;
			if (sr === 1'b1) n++;
		end
	endtask
	initial begin
		repeat (90000) @(posedge sys_clk);
		bad_count++;
		test_done;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] v;
		logic [3:0] m;
		logic [1:0] e;
		int k, n, r;
		k = $urandom(32'h789e);
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge sys_clk);
		noise <= 16'($urandom);
		rd(DEV_PMA, OFS_TX_TEST_PATTERN_CONTROL, v);
		chk("test ctl", v, 16'h0000);
		wr(DEV_PCS, OFS_PCS_STATUS_ONE, 16'hffff);
		rd(DEV_PCS, OFS_PCS_STATUS_ONE, v);
		chk("status one", v, 16'h0002);
		wr(DEV_PMA, OFS_NOISE_METRIC, ~noise);
		rd(DEV_PMA, OFS_NOISE_METRIC, v);
		chk("noise", v, noise);
		// post-read-increment: the unmapped word below reads zero, then the pointer moves on
		host.frame(OP_ADDRESS, DEV_PMA, OFS_NOISE_METRIC - 16'h0001, v);
		host.frame(OP_READ_INC, DEV_PMA, 16'h0000, v);
		chk("read inc", v, 16'h0000);
		host.frame(2'h3, DEV_PMA, 16'h0000, v);
		chk("noise after inc", v, noise);
		rd(DEV_PMA, 16'h1234, v);
		chk("unmapped", v, 16'h0000);
		host.frame(OP_ADDRESS, DEV_PMA, OFS_PMA_LINK_HEALTH, v);
		health;
		health;
		for (k = 0; k < 4; k++) begin
			m = 4'($urandom) | (4'h1 << k);
			@(posedge sys_clk);
			live <= ~m;
			held &= ~m;
			repeat (3) @(posedge sys_clk);
			live <= 4'hf;
			health;
			health;
		end
		for (k = 0; k < 5; k++) begin
			wr(DEV_PMA, OFS_TX_TEST_PATTERN_CONTROL, {3'(k), 13'h0});
			rd(DEV_PMA, OFS_TX_TEST_PATTERN_CONTROL, v);
			chk("test ctl", v, {3'(k), 13'h0});
			chk("pattern", 16'(psel), 16'(k));
			chk("idle master", 16'({fm, fi}), 16'({2{k == 3}}));
			for (n = 0; n < 22; n++) begin
				r = $urandom % 3;
				e = r == 2 ? SYM_MINUS : 2'(r);
				@(posedge sys_clk);
				tick <= 1'b1;
				dsym <= e;
				@(posedge sys_clk);
				tick <= 1'b0;
				@(posedge sys_clk);
				#1;
				if (k == 1) e = n % 2 == 1 ? SYM_MINUS : SYM_PLUS;
				if (k == 2) e = n % 20 < 10 ? SYM_PLUS : SYM_MINUS;
				chk("symbol", 16'(txs), 16'(e));
			end
		end
		wr(DEV_PCS, OFS_PCS_CONTROL_ONE, 16'h4800);
		rd(DEV_PCS, OFS_PCS_CONTROL_ONE, v);
		chk("control one", v, 16'h4800);
		chk("loopback", 16'(lb), 16'h1);
		chk("power down", 16'(pd), 16'h1);
		fork
			wr(DEV_PCS, OFS_PCS_CONTROL_ONE, 16'hc800);
			count_sr(2400, n);
		join
		chk("reset span", 16'(n), 16'(SOFT_RESET_CYCLES));
		rd(DEV_PCS, OFS_PCS_CONTROL_ONE, v);
		chk("control one", v, 16'h0000);
		chk("pattern", 16'(psel), 16'h0);
		@(posedge sys_clk);
		a_pdw <= 1'b1;
		a_pd <= 1'b1;
		@(posedge sys_clk);
		a_pdw <= 1'b0;
		rd(DEV_PCS, OFS_PCS_CONTROL_ONE, v);
		chk("control one", v, 16'h0800);
		fork
			begin
				@(posedge sys_clk);
				a_rst <= 1'b1;
				@(posedge sys_clk);
				a_rst <= 1'b0;
			end
			count_sr(60, n);
		join
		chk("reset span", 16'(n), 16'(SOFT_RESET_CYCLES));
		rd(DEV_PCS, OFS_PCS_CONTROL_ONE, v);
		chk("control one", v, 16'h0000);
		test_done;
	end
endmodule
`default_nettype wire
